// >>> rtl/csda_decoder.sv
// Combinational decode and effective address forming of the store forms.
`timescale 1ns/1ps
`default_nettype none

module csda_decoder
    import csda_pkg::*;
(
    input  wire logic [15:0]     instr,
    input  wire logic [31:0]     base_value,
    input  wire logic [31:0]     index_value,
    input  wire logic [31:0]     source_value,
    input  wire logic [31:0]     stack_pointer,
    input  wire logic            align_check_enable,
    input  wire logic            unaligned_support_enable,
    input  wire csda_endian_t    endian_mode,
    output logic [2:0]           base_sel,
    output logic [2:0]           index_sel,
    output logic [2:0]           source_sel,
    output logic                 is_store,
    output logic                 align_fault,
    output var csda_store_req_t  req
);
    logic        is_word_imm;
    logic        is_word_reg;
    logic        is_word_sp;
    logic        is_byte_imm;
    logic        is_byte_reg;
    logic        is_word;
    logic [31:0] imm5_word;
    logic [31:0] imm5_byte;
    logic [31:0] imm8_word;
    logic [31:0] raw_addr;
    logic        misaligned;
    logic [31:0] eff_addr;
    logic [1:0]  lane;
    logic [31:0] word_data;

    assign is_word_imm = instr[OPC5_MSB:OPC5_LSB] == OP_WORD_IMM;
    assign is_word_reg = instr[OPC5_MSB:OPC7_LSB] == OP_WORD_REG;
    assign is_word_sp  = instr[OPC5_MSB:OPC5_LSB] == OP_WORD_SP;
    assign is_byte_imm = instr[OPC5_MSB:OPC5_LSB] == OP_BYTE_IMM;
    assign is_byte_reg = instr[OPC5_MSB:OPC7_LSB] == OP_BYTE_REG;
    assign is_word     = is_word_imm | is_word_reg | is_word_sp;
    assign is_store    = is_word | is_byte_imm | is_byte_reg;

    assign base_sel   = instr[BASE_LSB +: 3];
    assign index_sel  = instr[INDEX_LSB +: 3];
    assign source_sel = is_word_sp ? instr[SPSRC_LSB +: 3] : instr[SRC_LSB +: 3];

    assign imm5_word = {25'h0, instr[IMM5_MSB:IMM5_LSB], 2'b00};
    assign imm5_byte = {27'h0, instr[IMM5_MSB:IMM5_LSB]};
    assign imm8_word = {22'h0, instr[IMM8_MSB:IMM8_LSB], 2'b00};

    // A zero offset leaves the base value untouched.
    assign raw_addr = is_word_sp ? stack_pointer + imm8_word
                    : (is_word_reg | is_byte_reg) ? base_value + index_value
                    : base_value + (is_byte_imm ? imm5_byte : imm5_word);

    assign misaligned  = is_word && (raw_addr[1:0] != 2'b00);
    assign align_fault = misaligned && align_check_enable;

    // With the check off and no unaligned support the low address bits of a misaligned word store are dropped.
    assign eff_addr = (misaligned && !align_check_enable
                       && !unaligned_support_enable) ? {raw_addr[31:2], 2'b00} : raw_addr;

    // Word-invariant big endian flips the lane of a byte but not a word.
    assign lane = (endian_mode == CSDA_ENDIAN_WORD_BIG) ? ~eff_addr[1:0]
                                                         : eff_addr[1:0];
    assign word_data = (endian_mode == CSDA_ENDIAN_BYTE_BIG) ?
                       {source_value[7:0], source_value[15:8],
                        source_value[23:16], source_value[31:24]} : source_value;

    assign req.addr  = eff_addr;
    assign req.wdata = is_word ? word_data : {4{source_value[7:0]}};
    assign req.store_byte_op  = is_word ? 4'hf : 4'(4'h1 << lane);
    assign req.size  = is_word ? CSDA_SIZE_WORD : CSDA_SIZE_BYTE;

endmodule // csda_decoder

`default_nettype wire

// >>> rtl/csda_pkg.sv
// Constants and types shared by the compact store decoder and address unit.
package csda_pkg;

    // Opcode patterns of the five store forms.
    localparam logic [4:0] OP_WORD_IMM = 5'h0c;
    localparam logic [6:0] OP_WORD_REG = 7'h28;
    localparam logic [4:0] OP_WORD_SP  = 5'h12;
    localparam logic [4:0] OP_BYTE_IMM = 5'h0e;
    localparam logic [6:0] OP_BYTE_REG = 7'h2a;

    // Field positions inside the 16-bit instruction.
    localparam int OPC5_MSB  = 15;
    localparam int OPC5_LSB  = 11;
    localparam int OPC7_LSB  = 9;
    localparam int IMM5_MSB  = 10;
    localparam int IMM5_LSB  = 6;
    localparam int INDEX_LSB = 6;
    localparam int BASE_LSB  = 3;
    localparam int SRC_LSB   = 0;
    localparam int SPSRC_LSB = 8;
    localparam int IMM8_MSB  = 7;
    localparam int IMM8_LSB  = 0;

    // Register byte offsets.
    localparam logic [31:0] OFF_CTRL        = 32'h0000_0000;
    localparam logic [31:0] OFF_STATUS      = 32'h0000_0004;
    localparam logic [31:0] OFF_STORE_COUNT = 32'h0000_0008;
    localparam logic [31:0] OFF_ABORT_COUNT = 32'h0000_000c;
    localparam logic [31:0] OFF_ABORT_ADDR  = 32'h0000_0010;

    // Control register fields and reset value.
    localparam int          CTRL_ALIGN_BIT   = 0;
    localparam int          CTRL_UNALIGN_BIT = 1;
    localparam int          CTRL_ENDIAN_LSB  = 2;
    localparam int          CTRL_ENDIAN_MSB  = 3;
    localparam logic [3:0]  CTRL_RESET       = 4'h0;
    localparam logic [31:0] COUNT_RESET      = 32'h0000_0000;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CSDA_ENDIAN_LITTLE   = 2'h0,
        CSDA_ENDIAN_BYTE_BIG = 2'h1,
        CSDA_ENDIAN_WORD_BIG = 2'h2
    } csda_endian_t;

    typedef enum logic [1:0] {
        CSDA_SIZE_BYTE = 2'h0,
        CSDA_SIZE_WORD = 2'h2
    } csda_size_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_REQ  = 3'b010,
        ST_RESP = 3'b100
    } csda_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  store_byte_op;
        csda_size_t  size;
    } csda_store_req_t;

    typedef struct packed {
        logic        alignment;
        logic [31:0] addr;
    } csda_abort_t;

endpackage

// >>> rtl/csda_store_agu.sv
// Top of the compact store decoder and address unit with its bus slave.
`timescale 1ns/1ps
`default_nettype none

module csda_store_agu
    import csda_pkg::*;
(
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            issue_valid,
    output logic                 issue_ready,
    input  wire logic [15:0]     instr,
    output logic [2:0]           base_sel,
    output logic [2:0]           index_sel,
    output logic [2:0]           source_sel,
    input  wire logic [31:0]     base_value,
    input  wire logic [31:0]     index_value,
    input  wire logic [31:0]     source_value,
    input  wire logic [31:0]     stack_pointer,
    output logic                 mem_req_valid,
    input  wire logic            mem_req_ready,
    output var csda_store_req_t  mem_req,
    input  wire logic            mem_resp_valid,
    output logic                 mem_resp_ready,
    input  wire logic            mem_resp_abort,
    output logic                 store_done,
    output logic                 data_abort_valid,
    output var csda_abort_t      data_abort,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire logic [31:0]     awaddr,
    input  wire logic            wvalid,
    output logic                 wready,
    input  wire logic [31:0]     wdata,
    input  wire logic [3:0]      wstrb,
    output logic                 bvalid,
    input  wire logic            bready,
    output logic [1:0]           bresp,
    input  wire logic            arvalid,
    output logic                 arready,
    input  wire logic [31:0]     araddr,
    output logic                 rvalid,
    input  wire logic            rready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp
);

    function automatic logic reg_mapped(input logic [31:0] byte_addr);
        reg_mapped = (byte_addr == OFF_CTRL) || (byte_addr == OFF_STATUS) ||
                     (byte_addr == OFF_STORE_COUNT) || (byte_addr == OFF_ABORT_COUNT) ||
                     (byte_addr == OFF_ABORT_ADDR);
    endfunction

    csda_state_t     state;
    csda_state_t     next_state;
    logic [3:0]      ctrl;
    logic [31:0]     store_count;
    logic [31:0]     abort_count;
    logic [31:0]     last_abort_addr;
    logic            last_abort_alignment;
    logic            aw_held;
    logic            w_held;
    logic [31:0]     aw_addr_held;
    logic [31:0]     w_data_held;
    logic [3:0]      w_store_byte_op_held;

    logic            align_check_enable;
    logic            unaligned_support_enable;
    csda_endian_t    endian_mode;
    logic            dec_store;
    logic            dec_fault;
    csda_store_req_t dec_req;
    logic            accept;
    logic            issue_ok;
    logic            issue_fault;
    logic            req_taken;
    logic            resp_take;
    logic            abort_event;
    logic            do_write;
    logic            ctrl_write;
    logic            read_take;
    logic [31:0]     read_value;

    assign align_check_enable       = ctrl[CTRL_ALIGN_BIT];
    assign unaligned_support_enable = ctrl[CTRL_UNALIGN_BIT];
    assign endian_mode = (ctrl[CTRL_ENDIAN_MSB:CTRL_ENDIAN_LSB] == 2'h1) ? CSDA_ENDIAN_BYTE_BIG
                       : (ctrl[CTRL_ENDIAN_MSB:CTRL_ENDIAN_LSB] == 2'h2) ? CSDA_ENDIAN_WORD_BIG
                       : CSDA_ENDIAN_LITTLE;

    csda_decoder u_decoder (
        .instr                    (instr),
        .base_value               (base_value),
        .index_value              (index_value),
        .source_value             (source_value),
        .stack_pointer            (stack_pointer),
        .align_check_enable       (align_check_enable),
        .unaligned_support_enable (unaligned_support_enable),
        .endian_mode              (endian_mode),
        .base_sel                 (base_sel),
        .index_sel                (index_sel),
        .source_sel               (source_sel),
        .is_store                 (dec_store),
        .align_fault              (dec_fault),
        .req                      (dec_req)
    );

    // A non-store instruction is taken and dropped without any effect.
    assign issue_ready    = (state == ST_IDLE);
    assign accept         = issue_valid && issue_ready;
    assign issue_ok       = accept && dec_store && !dec_fault;
    assign issue_fault    = accept && dec_store && dec_fault;
    assign req_taken      = mem_req_valid && mem_req_ready;
    assign mem_resp_ready = (state == ST_RESP);
    assign resp_take      = mem_resp_valid && mem_resp_ready;
    assign abort_event    = issue_fault || (resp_take && mem_resp_abort);

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (issue_ok) next_state = ST_REQ;
            ST_REQ:  if (req_taken) next_state = ST_RESP;
            ST_RESP: if (resp_take) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // The request stays unchanged until the memory system takes it.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mem_req_valid <= 1'b0;
            mem_req       <= '0;
        end
        else if (issue_ok)
        begin
            mem_req_valid <= 1'b1;
            mem_req       <= dec_req;
        end
        else if (req_taken)
        begin
            mem_req_valid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            data_abort_valid <= 1'b0;
            data_abort       <= '0;
            store_done       <= 1'b0;
        end
        else
        begin
            data_abort_valid <= abort_event;
            data_abort       <= issue_fault ? csda_abort_t'{alignment: 1'b1, addr: dec_req.addr}
                              : csda_abort_t'{alignment: 1'b0, addr: mem_req.addr};
            store_done       <= resp_take && !mem_resp_abort;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            store_count          <= COUNT_RESET;
            abort_count          <= COUNT_RESET;
            last_abort_addr      <= COUNT_RESET;
            last_abort_alignment <= 1'b0;
        end
        else
        begin
            if (resp_take && !mem_resp_abort)
            begin
                store_count <= store_count + 32'h1;
            end
            if (abort_event)
            begin
                abort_count          <= abort_count + 32'h1;
                last_abort_addr      <= issue_fault ? dec_req.addr : mem_req.addr;
                last_abort_alignment <= issue_fault;
            end
        end
    end

    // Write address and write data are held apart and joined when both arrived.
    assign awready    = !aw_held && !bvalid;
    assign wready     = !w_held && !bvalid;
    assign do_write   = aw_held && w_held && !bvalid;
    assign ctrl_write = do_write && (aw_addr_held == OFF_CTRL) && w_store_byte_op_held[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr_held <= 32'h0;
            w_data_held  <= 32'h0;
            w_store_byte_op_held  <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held      <= 1'b1;
                aw_addr_held <= awaddr;
            end
            else if (do_write)
            begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_held      <= 1'b1;
                w_data_held <= wdata;
                w_store_byte_op_held <= wstrb;
            end
            else if (do_write)
            begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
            ctrl   <= CTRL_RESET;
        end
        else
        begin
            if (do_write)
            begin
                bvalid <= 1'b1;
                bresp  <= reg_mapped(aw_addr_held) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bready)
            begin
                bvalid <= 1'b0;
            end
            if (ctrl_write)
            begin
                ctrl <= w_data_held[3:0];
            end
        end
    end

    assign arready   = !rvalid;
    assign read_take = arvalid && arready;
    assign read_value = (araddr == OFF_CTRL)        ? {28'h0, ctrl}
                      : (araddr == OFF_STATUS)      ? {28'h0, last_abort_alignment, state}
                      : (araddr == OFF_STORE_COUNT) ? store_count
                      : (araddr == OFF_ABORT_COUNT) ? abort_count
                      : (araddr == OFF_ABORT_ADDR)  ? last_abort_addr
                      : 32'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= RESP_OKAY;
        end
        else if (read_take)
        begin
            rvalid <= 1'b1;
            rdata  <= read_value;
            rresp  <= reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rready)
        begin
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_take(logic [15:0] mask, logic [15:0] pattern);
        accept && ((instr & mask) == pattern) && !dec_fault;
    endsequence

    sequence s_issued;
        mem_req_valid && (state == ST_REQ);
    endsequence

    property p_word_imm_addr;
        s_take(16'hf800, 16'h6000) ##0 (base_value[1:0] == 2'b00)
        |=> s_issued ##0 (mem_req.addr ==
            $past(base_value) + {25'h0, $past(instr[10:6]), 2'b00})
            ##0 (mem_req.size == CSDA_SIZE_WORD);
    endproperty
    a_word_imm_addr: assert property (p_word_imm_addr)
        else $error("word immediate store address wrong");

    property p_word_imm_data;
        s_take(16'hf800, 16'h6000) ##0 (ctrl[CTRL_ENDIAN_MSB:CTRL_ENDIAN_LSB] == 2'h0)
        |=> s_issued ##0 (mem_req.wdata == $past(source_value))
            ##0 (mem_req.store_byte_op == 4'hf);
    endproperty
    a_word_imm_data: assert property (p_word_imm_data)
        else $error("word immediate store data wrong");

    property p_zero_offset;
        s_take(16'hffc0, 16'h7000) |=> s_issued ##0 (mem_req.addr == $past(base_value));
    endproperty
    a_zero_offset: assert property (p_zero_offset)
        else $error("zero offset store did not use the plain base");

    property p_word_reg_addr;
        s_take(16'hfe00, 16'h5000) ##0 (((base_value + index_value) & 32'h3) == 32'h0)
        |=> s_issued ##0 (mem_req.addr == $past(base_value) + $past(index_value));
    endproperty
    a_word_reg_addr: assert property (p_word_reg_addr)
        else $error("word register store address wrong");

    property p_stack_addr;
        s_take(16'hf800, 16'h9000) ##0 (stack_pointer[1:0] == 2'b00)
        |=> s_issued ##0 (mem_req.addr ==
            $past(stack_pointer) + {22'h0, $past(instr[7:0]), 2'b00});
    endproperty
    a_stack_addr: assert property (p_stack_addr)
        else $error("stack store address wrong");

    property p_stack_source;
        accept && (instr[15:11] == OP_WORD_SP) |-> (source_sel == instr[10:8]);
    endproperty
    a_stack_source: assert property (p_stack_source)
        else $error("stack store source register wrong");

    property p_byte_imm_addr;
        s_take(16'hf800, 16'h7000)
        |=> s_issued ##0 (mem_req.addr == $past(base_value) + {27'h0, $past(instr[10:6])});
    endproperty
    a_byte_imm_addr: assert property (p_byte_imm_addr)
        else $error("byte immediate store address wrong");

    property p_byte_lane;
        accept && dec_store && (dec_req.size == CSDA_SIZE_BYTE)
        |=> s_issued ##0 $onehot(mem_req.store_byte_op)
            ##0 (mem_req.wdata[7:0] == $past(source_value[7:0]));
    endproperty
    a_byte_lane: assert property (p_byte_lane)
        else $error("byte store touches more than one lane");

    property p_byte_reg_addr;
        s_take(16'hfe00, 16'h5400)
        |=> s_issued ##0 (mem_req.addr == $past(base_value) + $past(index_value))
            ##0 (mem_req.size == CSDA_SIZE_BYTE);
    endproperty
    a_byte_reg_addr: assert property (p_byte_reg_addr)
        else $error("byte register store address wrong");

    property p_align_abort;
        accept && dec_store && align_check_enable && (dec_req.size == CSDA_SIZE_WORD)
        && (dec_req.addr[1:0] != 2'b00)
        |=> data_abort_valid && data_abort.alignment && !mem_req_valid
            ##1 !data_abort_valid;
    endproperty
    a_align_abort: assert property (p_align_abort)
        else $error("unaligned word store not aborted");

    property p_unaligned_kept;
        s_take(16'hfe00, 16'h5000) ##0 !align_check_enable ##0 unaligned_support_enable
        |=> s_issued ##0 (mem_req.addr == $past(base_value) + $past(index_value));
    endproperty
    a_unaligned_kept: assert property (p_unaligned_kept)
        else $error("supported unaligned store lost its address bits");

    property p_mem_abort;
        resp_take && mem_resp_abort |=> data_abort_valid && !data_abort.alignment && !store_done;
    endproperty
    a_mem_abort: assert property (p_mem_abort)
        else $error("memory abort not passed on");

    property p_req_hold;
        mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("store request changed before it was taken");

endmodule // csda_store_agu

`default_nettype wire

// >>> verification/compact_store_decode_agu_tb_top.sv
// Testbench of the compact store decoder and address unit.
`timescale 1ns/1ps
`default_nettype none
module compact_store_decode_agu_tb_top
    import csda_pkg::*;
;
    typedef struct packed {logic [3:0] c; logic [1:0] k; logic [7:0] x;
        logic [15:0] i; logic [31:0] a, d; logic [3:0] s;} csda_row_t;
    localparam logic [31:0] B = 32'h1000_0000, S = 32'h1122_3344, P = 32'h2000_0000;
    logic aclk = 0, aresetn = 0, issue_valid = 0, issue_ready, mem_req_valid, mem_req_ready;
    logic mem_resp_valid, mem_resp_ready, mem_resp_abort, store_done, data_abort_valid;
    logic abort_next = 0, awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
    logic arvalid = 0, arready, rvalid, rready = 0, dn;
    logic [15:0] instr = 0;
    logic [2:0] base_sel, index_sel, source_sel;
    logic [31:0] base_value = B, index_value = 0, source_value = S, stack_pointer = P;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp, rr;
    logic [7:0] nreq, n0;
    csda_store_req_t mem_req, last_req;
    csda_abort_t data_abort, ab;
    csda_row_t rows [11];
    int num_errors = 0, total_checks = 0;
    always #20 aclk = ~aclk;
    csda_store_agu i_dut (.*);
    csda_mem_model i_mem (.*);
    task automatic check(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic ta, tw, tb;
        @(posedge aclk);
        {awvalid, wvalid, bready, awaddr, wdata, wstrb} <= {3'h7, a, d, 4'hf};
        do
        begin
            @(negedge aclk);
            {ta, tw, tb} = {awready & awvalid, wready & wvalid, bvalid & bready};
            if (tb) rr = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            if (tb) bready <= 0;
        end
        while (awvalid || wvalid || bready);
    endtask
    task automatic rdt(input logic [31:0] a);
        logic ta, tr;
        @(posedge aclk);
        {arvalid, rready, araddr} <= {2'h3, a};
        do
        begin
            @(negedge aclk);
            {ta, tr} = {arready & arvalid, rvalid & rready};
            if (tr) {rd, rr} = {rdata, rresp};
            @(posedge aclk);
            if (ta) arvalid <= 0;
            if (tr) rready <= 0;
        end
        while (arvalid || rready);
    endtask
    task automatic run(input csda_row_t r);
        wr(OFF_CTRL, {28'h0, r.c});
        check(rr, RESP_OKAY);
        {abort_next, index_value, instr, issue_valid} <= {r.k == 2, 24'h0, r.x, r.i, 1'b1};
        n0 = nreq;
        @(posedge aclk);
        issue_valid <= 0;
        dn = 0;
        for (int n = 0; n < 50 && !dn; n++)
        begin
            @(negedge aclk);
            {dn, ab} = {store_done | data_abort_valid, data_abort};
        end
        check(dn, 1);
        check(base_sel, r.i[5:3]);
        check(index_sel, r.i[8:6]);
        check(source_sel, r.i[15:11] == OP_WORD_SP ? r.i[10:8] : r.i[2:0]);
        check(data_abort_valid, r.k != 0);
        if (r.k != 0)
        begin
            check(ab.alignment, r.k == 1);
            check(ab.addr, r.a);
            if (r.k == 1) check(nreq, n0);
        end
        else
        begin
            check(last_req.addr, r.a);
            check(last_req.wdata, r.d);
            check(last_req.store_byte_op, r.s);
            check(last_req.size, r.s == 4'hf ? CSDA_SIZE_WORD : CSDA_SIZE_BYTE);
        end
    endtask
    initial
    begin
        rows[0] = '{0, 0, 8'h24, {OP_WORD_IMM, 5'd5, 6'h0a}, B + 20, S, 15};
        rows[1] = '{0, 0, 8'h24, {OP_WORD_IMM, 5'd0, 6'h0a}, B, S, 15};
        rows[2] = '{0, 0, 8'h24, {OP_WORD_REG, 9'h0ca}, B + 36, S, 15};
        rows[3] = '{0, 0, 8'h24, {OP_WORD_SP, 11'h2ff}, P + 1020, S, 15};
        rows[4] = '{0, 0, 8'h24, {OP_BYTE_IMM, 5'd7, 6'h0a}, B + 7, 32'h4444_4444, 8};
        rows[5] = '{0, 0, 8'h25, {OP_BYTE_REG, 9'h0ca}, B + 37, 32'h4444_4444, 2};
        rows[6] = '{1, 1, 8'h26, {OP_WORD_REG, 9'h0ca}, B + 38, 0, 0};
        rows[7] = '{2, 0, 8'h26, {OP_WORD_REG, 9'h0ca}, B + 38, S, 15};
        rows[8] = '{4, 0, 8'h24, {OP_WORD_REG, 9'h0ca}, B + 36, 32'h4433_2211, 15};
        rows[9] = '{8, 0, 8'h24, {OP_BYTE_IMM, 5'd7, 6'h0a}, B + 7, 32'h4444_4444, 1};
        rows[10] = '{0, 2, 8'h24, {OP_WORD_REG, 9'h0ca}, B + 36, 0, 0};
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rdt(OFF_CTRL);
        check(rd, 0);
        foreach (rows[i])
        begin
            run(rows[i]);
            $display("row %0d done", i);
        end
        rdt(32'h0000_0020);
        check(rr, RESP_SLVERR);
        rdt(OFF_ABORT_COUNT);
        check(rd, 2);
        rdt(OFF_STORE_COUNT);
        check(rd, 9);
        $display("register test done");
        wr(OFF_CTRL, 32'h0000_0003);
        aresetn <= 0;
        @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk);
        check(issue_ready, 1);
        check(awready, 1);
        rdt(OFF_CTRL);
        check(rd, 0);
        rdt(OFF_ABORT_COUNT);
        check(rd, 0);
        $display("reset test done");
        print_verdict;
    end
    initial
    begin
        #200000;
        num_errors++;
        print_verdict;
    end
endmodule // compact_store_decode_agu_tb_top
`default_nettype wire

// >>> verification/csda_mem_model.sv
// Memory system model that takes store requests and answers them.
`timescale 1ns/1ps
`default_nettype none
module csda_mem_model
    import csda_pkg::*;
(
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            mem_req_valid,
    input  wire csda_store_req_t mem_req,
    input  wire logic            mem_resp_ready,
    input  wire logic            abort_next,
    output logic                 mem_req_ready,
    output logic                 mem_resp_valid,
    output logic                 mem_resp_abort,
    output csda_store_req_t      last_req,
    output logic [7:0]           nreq
);
    logic pend;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mem_req_ready  <= 1'b0;
            mem_resp_valid <= 1'b0;
            pend           <= 1'b0;
            nreq           <= 8'h00;
        end
        else
        begin
            mem_req_ready  <= mem_req_valid & ~mem_req_ready;
            mem_resp_valid <= pend & mem_resp_ready & ~mem_resp_valid;
            if (mem_req_valid && mem_req_ready)
            begin
                last_req <= mem_req;
                nreq     <= nreq + 8'h01;
                pend     <= 1'b1;
            end
            if (mem_resp_valid)
                pend <= 1'b0;
        end
        // Outside an answer the abort line toggles, so no stale value passes.
        mem_resp_abort <= pend ? abort_next : ~mem_resp_abort;
    end
endmodule // csda_mem_model
`default_nettype wire
